// *** shs_pkg.sv ***
package shs_pkg;
   // Position is kept in thousandths of an inch
   localparam int POS_W = 20;
   localparam int TICK_W = 16;
   localparam int CODE_W = 16;
   localparam int DEB_W = 8;
   // Debounce settle time, in microseconds, and derived cycle count
   localparam int CLK_MHZ = 100;
   localparam int DEB_US = 1;
   localparam int DEB_CYC = DEB_US * CLK_MHZ;
   // Move timer prescaler: one tick per millisecond
   localparam int MS_CYC = 100000;
   localparam logic [16:0] MS_LAST = 17'(MS_CYC - 1);
   // Millimetre scaling: mm*1000 = thou * 254 / 10
   localparam logic [POS_W+8:0] MM_NUM = 29'h00000FE;
   localparam logic [POS_W+8:0] MM_DEN = 29'h000000A;
   localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEB_CYC - 1);

   typedef enum logic [1:0] {SHS_IDLE, SHS_TIMING, SHS_MOVED, SHS_JAM}
      shs_move_t;

   // Configuration carried as one group
   typedef struct packed {
      logic [POS_W-1:0] upperLimit;
      logic [POS_W-1:0] lowerLimit;
      logic [TICK_W-1:0] moveTimeout;
      logic unitMm;
      logic upperNormClosed;
      logic lowerNormClosed;
      logic relayPresent;
   } shs_cfg_t;

   // Status carried as one group
   typedef struct packed {
      logic [POS_W-1:0] display;
      logic holdActive;
      logic jamError;
      logic upperRelay;
      logic lowerRelay;
      logic progMode;
   } shs_stat_t;
endpackage

// *** shs_supervisor.sv ***
`timescale 1ns/1ns
// What this block does
// - Past an end limit the matching relay drops if set normally open and pulls in if set normally closed, only if fitted.
// - While hold is on the display keeps its last captured value.
// - When hold is released the display follows position again.
// - The move timer starts when motor power is detected.
// - The move timer stops as soon as motion is sensed.
// - Timeout without motion drops both relays and flags an error.
// - Position is shown in inches or millimetres by a setting.
// - Program mode is entered only with the correct access code.
// - Each relay can be set normally open or normally closed.
// - Position resolves to one thousandth of an inch.
// - One auxiliary input drives both hold and timer start.
module shs_supervisor #(
   parameter logic [shs_pkg::CODE_W-1:0] ACCESS_CODE = 16'h1234
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [shs_pkg::POS_W-1:0] position,
   input wire logic auxIn,
   input wire shs_pkg::shs_cfg_t cfg,
   input wire logic progRequest,
   input wire logic progExit,
   input wire logic [shs_pkg::CODE_W-1:0] accessCode,
   input wire logic errorClear,
   output shs_pkg::shs_stat_t stat
);
   logic aux1_q, aux2_q, auxDeb_q;
   logic [shs_pkg::DEB_W-1:0] debCnt_q;
   logic [shs_pkg::POS_W-1:0] held_q, startPos_q, disp_q;
   logic [16:0] msCnt_q;
   logic [shs_pkg::TICK_W-1:0] tick_q;
   shs_pkg::shs_move_t state_q, state_d;
   logic jam_q, prog_q, upRel_q, loRel_q;
   logic auxRise, moved, timeout, overUp, underLo, upOn, loOn;
   logic [shs_pkg::POS_W+8:0] mmWide;
   logic [shs_pkg::POS_W-1:0] shown;

   // Two-stage synchroniser; first stage read only by second
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         aux1_q <= 1'b0;
         aux2_q <= 1'b0;
      end
      else
      begin
         aux1_q <= auxIn;
         aux2_q <= aux1_q;
      end
   end

   // Debounce: level must hold steady for the full settle count
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         debCnt_q <= '0;
         auxDeb_q <= 1'b0;
      end
      else if (aux2_q == auxDeb_q)
         debCnt_q <= '0;
      else if (debCnt_q == shs_pkg::DEB_LAST)
      begin
         debCnt_q <= '0;
         auxDeb_q <= aux2_q;
      end
      else
         debCnt_q <= debCnt_q + 1'b1;
   end

   // One debounced level feeds both hold and timer start
   assign auxRise = aux2_q && !auxDeb_q && (debCnt_q == shs_pkg::DEB_LAST);

   // Capture while released, freeze while held
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         held_q <= '0;
      else if (!auxDeb_q)
         held_q <= position; // Thousandths of an inch
   end

   // Unit conversion; divide is costly but runs once per clock
   assign mmWide = ({9'h000, held_q} * shs_pkg::MM_NUM) / shs_pkg::MM_DEN;
   assign shown = cfg.unitMm ? mmWide[shs_pkg::POS_W-1:0] : held_q;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         disp_q <= '0;
      else
         disp_q <= shown;
   end

   // Motion is any count difference from start position
   assign moved = (position != startPos_q);
   assign timeout = (tick_q >= cfg.moveTimeout);

   // Move detection state machine
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         shs_pkg::SHS_IDLE:
            if (auxRise)
               state_d = shs_pkg::SHS_TIMING;
         shs_pkg::SHS_TIMING:
            if (moved)
               state_d = shs_pkg::SHS_MOVED;
            else if (timeout)
               state_d = shs_pkg::SHS_JAM;
         shs_pkg::SHS_MOVED:
            if (!auxDeb_q)
               state_d = shs_pkg::SHS_IDLE;
         shs_pkg::SHS_JAM:
            if (errorClear)
               state_d = shs_pkg::SHS_IDLE;
         default:
            state_d = shs_pkg::SHS_IDLE;
      endcase
   end

   // Timer and start snapshot
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_q <= shs_pkg::SHS_IDLE;
         startPos_q <= '0;
         msCnt_q <= '0;
         tick_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         if (state_q != shs_pkg::SHS_TIMING)
         begin
            startPos_q <= position;
            msCnt_q <= '0;
            tick_q <= '0;
         end
         else if (msCnt_q == shs_pkg::MS_LAST)
         begin
            msCnt_q <= '0;
            tick_q <= tick_q + 1'b1;
         end
         else
            msCnt_q <= msCnt_q + 1'b1;
      end
   end

   // Jam flag; a new jam wins over a same-cycle clear
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         jam_q <= 1'b0;
      else if (state_d == shs_pkg::SHS_JAM)
         jam_q <= 1'b1;
      else if (errorClear)
         jam_q <= 1'b0;
   end

   // Access-code gate for program mode
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         prog_q <= 1'b0;
      else if (progRequest && accessCode == ACCESS_CODE)
         prog_q <= 1'b1;
      else if (progExit)
         prog_q <= 1'b0;
   end

   // Limits compare the live position, not the held one
   assign overUp = (position > cfg.upperLimit);
   assign underLo = (position < cfg.lowerLimit);
   // Sense flips the limit action; a jam drops coils whatever the sense
   assign upOn = ((!overUp) ^ cfg.upperNormClosed) && !jam_q;
   assign loOn = ((!underLo) ^ cfg.lowerNormClosed) && !jam_q;

   // Relay drive with contact sense, held off when not fitted
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         upRel_q <= 1'b0;
         loRel_q <= 1'b0;
      end
      else
      begin
         upRel_q <= cfg.relayPresent && upOn;
         loRel_q <= cfg.relayPresent && loOn;
      end
   end

   // Status gathered in one place, one driver for the whole group
   assign stat = '{
      display: disp_q,
      holdActive: auxDeb_q,
      jamError: jam_q,
      upperRelay: upRel_q,
      lowerRelay: loRel_q,
      progMode: prog_q
   };

   // Checks beside the logic; one clock, all off during reset
   property p_hold_freeze;
      @(posedge clk) disable iff (!reset_n)
      auxDeb_q && $past(auxDeb_q) |-> held_q == $past(held_q);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze)
      else $error("hold moved");

   property p_release_track;
      @(posedge clk) disable iff (!reset_n)
      !auxDeb_q |=> held_q == $past(position);
   endproperty
   a_release_track: assert property (p_release_track)
      else $error("no track");

   // A level change only after the full settle count
   property p_debounce;
      @(posedge clk) disable iff (!reset_n)
      auxDeb_q != $past(auxDeb_q) |-> $past(debCnt_q) == shs_pkg::DEB_LAST;
   endproperty
   a_debounce: assert property (p_debounce)
      else $error("debounce skipped");

   property p_start;
      @(posedge clk) disable iff (!reset_n)
      state_q == shs_pkg::SHS_IDLE && auxRise
      |=> state_q == shs_pkg::SHS_TIMING;
   endproperty
   a_start: assert property (p_start)
      else $error("timer not started");

   property p_stop;
      @(posedge clk) disable iff (!reset_n)
      state_q == shs_pkg::SHS_TIMING && moved
      |=> state_q == shs_pkg::SHS_MOVED;
   endproperty
   a_stop: assert property (p_stop)
      else $error("timer not stopped");

   // Both coils off one cycle after the jam flag rises
   property p_jam;
      @(posedge clk) disable iff (!reset_n)
      state_q == shs_pkg::SHS_TIMING && !moved && timeout
      |=> jam_q ##1 (!upRel_q && !loRel_q);
   endproperty
   a_jam: assert property (p_jam)
      else $error("jam missed");

   // Jam indication stays up until cleared
   property p_jam_keep;
      @(posedge clk) disable iff (!reset_n)
      jam_q && !errorClear |=> jam_q;
   endproperty
   a_jam_keep: assert property (p_jam_keep)
      else $error("jam lost");

   property p_prog;
      @(posedge clk) disable iff (!reset_n)
      !prog_q && !(progRequest && accessCode == ACCESS_CODE) |=> !prog_q;
   endproperty
   a_prog: assert property (p_prog)
      else $error("bad entry");

   property p_absent;
      @(posedge clk) disable iff (!reset_n)
      !cfg.relayPresent |=> !upRel_q && !loRel_q;
   endproperty
   a_absent: assert property (p_absent)
      else $error("relay absent");

   property p_trip;
      @(posedge clk) disable iff (!reset_n)
      overUp && !cfg.upperNormClosed |=> !upRel_q;
   endproperty
   a_trip: assert property (p_trip)
      else $error("upper trip missed");

   property p_sense;
      @(posedge clk) disable iff (!reset_n)
      cfg.relayPresent && !jam_q && !overUp
      |=> upRel_q != $past(cfg.upperNormClosed);
   endproperty
   a_sense: assert property (p_sense)
      else $error("sense wrong");

   property p_inch;
      @(posedge clk) disable iff (!reset_n)
      !cfg.unitMm |=> disp_q == $past(held_q);
   endproperty
   a_inch: assert property (p_inch)
      else $error("inch display");

   // Main scenarios reached
   c_jam: cover property (@(posedge clk) disable iff (!reset_n) jam_q);
   c_moved: cover property (@(posedge clk) disable iff (!reset_n)
      state_q == shs_pkg::SHS_MOVED);
   c_prog: cover property (@(posedge clk) disable iff (!reset_n) prog_q);
   c_over: cover property (@(posedge clk) disable iff (!reset_n) overUp);
   c_hold: cover property (@(posedge clk) disable iff (!reset_n) auxDeb_q);
endmodule // shs_supervisor

// *** shs_motor_model.sv ***
`timescale 1ns/1ns
// Ram adjust motor and transducer stand-in
module shs_motor_model (
   input wire logic clk,
   input wire logic motorOn,
   input wire logic jammed,
   input wire logic loadPos,
   input wire logic [shs_pkg::POS_W-1:0] loadVal,
   output logic [shs_pkg::POS_W-1:0] position,
   output logic auxIn
);
   logic [7:0] stepCnt;
   // Aux senses motor power directly
   assign auxIn = motorOn;
   // Slow start so a hold capture sees a still ram
   always_ff @(posedge clk)
   begin
      if (loadPos)
      begin
         position <= loadVal;
         stepCnt <= 8'h00;
      end
      else if (motorOn && !jammed && stepCnt == 8'hC7)
      begin
         position <= position + 20'h00001;
         stepCnt <= 8'h00;
      end
      else if (motorOn)
         stepCnt <= stepCnt + 8'h01;
      else
         stepCnt <= 8'h00;
   end
endmodule // shs_motor_model

// *** tb_shs_supervisor.sv ***
`timescale 1ns/1ns
module tb_shs_supervisor;
   logic clk, reset_n, motorOn, jammed, loadPos, auxIn;
   logic progRequest, progExit, errorClear;
   logic [shs_pkg::POS_W-1:0] position, loadVal;
   logic [shs_pkg::CODE_W-1:0] accessCode;
   shs_pkg::shs_cfg_t cfg;
   shs_pkg::shs_stat_t stat;
   int failures, comparisons;
   logic [19:0] tPos [5] = '{20'h001F4, 20'h003E9, 20'h003E8, 20'h00063,
      20'h00064};
   logic [4:0] uExp = 5'b11101;
   logic [4:0] lExp = 5'b10111;

   shs_supervisor #(.ACCESS_CODE(16'h1234)) i_shs_supervisor (.clk(clk),
      .reset_n(reset_n), .position(position), .auxIn(auxIn), .cfg(cfg),
      .progRequest(progRequest), .progExit(progExit),
      .accessCode(accessCode), .errorClear(errorClear), .stat(stat));
   shs_motor_model i_shs_motor_model (.clk(clk), .motorOn(motorOn),
      .jammed(jammed), .loadPos(loadPos), .loadVal(loadVal),
      .position(position), .auxIn(auxIn));

   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Load the ram position, then let display settle
   task setPos(input logic [19:0] p);
      loadVal = p;
      loadPos = 1'b1;
      cyc(1);
      loadPos = 1'b0;
      cyc(3);
   endtask
   // Pulse one control input for a cycle
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(2);
   endtask
   task final_report;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Free running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard, about fourteen times the length of the sequence
   initial
   begin
      #100000;
      failures++;
      final_report();
   end

   // Main sequence, inputs move at falling edges
   initial
   begin
      {reset_n, motorOn, jammed, progRequest, progExit, errorClear} = 6'h00;
      loadPos = 1'b1;
      loadVal = 20'h001F4;
      accessCode = 16'h0000;
      cfg = '{20'h003E8, 20'h00064, 16'h0005, 1'b0, 1'b0, 1'b0, 1'b1};
      cyc(20);
      chk(stat, 0);
      reset_n = 1'b1;
      loadPos = 1'b0;
      // Limit table, boundaries included
      for (int i = 0; i < 5; i++)
      begin
         setPos(tPos[i]);
         chk(stat.display, tPos[i]);
         chk(stat.upperRelay, uExp[i]);
         chk(stat.lowerRelay, lExp[i]);
      end
      cfg.upperNormClosed = 1'b1;
      cfg.lowerNormClosed = 1'b1;
      cyc(3);
      chk({stat.upperRelay, stat.lowerRelay}, 2'b00);
      setPos(20'h00063);
      chk({stat.upperRelay, stat.lowerRelay}, 2'b01);
      cfg.upperNormClosed = 1'b0;
      cfg.lowerNormClosed = 1'b0;
      cfg.relayPresent = 1'b0;
      setPos(20'h001F4);
      chk({stat.upperRelay, stat.lowerRelay}, 2'b00);
      cfg.relayPresent = 1'b1;
      cfg.unitMm = 1'b1;
      setPos(20'h003E8);
      chk(stat.display, 20'h06338);
      cfg.unitMm = 1'b0;
      // Hold while the motor runs; hold waits for the settle count
      setPos(20'h001F4);
      motorOn = 1'b1;
      cyc(50);
      chk(stat.holdActive, 1'b0);
      cyc(60);
      chk(stat.holdActive, 1'b1);
      cyc(200);
      chk(stat.display, 20'h001F4);
      chk(stat.jamError, 1'b0);
      chk(position, 20'h001F5);
      motorOn = 1'b0;
      cyc(110);
      chk(stat.display, position);
      // Stalled ram with zero timeout gives a jam
      cfg.moveTimeout = 16'h0000;
      jammed = 1'b1;
      motorOn = 1'b1;
      cyc(50);
      chk(stat.jamError, 1'b0);
      cyc(60);
      chk(stat.jamError, 1'b1);
      chk({stat.upperRelay, stat.lowerRelay}, 2'b00);
      motorOn = 1'b0;
      cyc(110);
      pulse(errorClear);
      chk({stat.jamError, stat.upperRelay}, 2'b01);
      // Program mode refuses a wrong code
      accessCode = 16'h1235;
      pulse(progRequest);
      chk(stat.progMode, 1'b0);
      accessCode = 16'h1234;
      pulse(progRequest);
      chk(stat.progMode, 1'b1);
      pulse(progExit);
      chk(stat.progMode, 1'b0);
      final_report();
   end
endmodule // tb_shs_supervisor
